// ---- include/crs_pkg.sv ----
`default_nettype none
package crs_pkg;

  // --------------------------------------------------------------------
  // States and commands
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    wait_for_activation,
    wait_for_challenge_answer,
    wait_for_card
  } crs_main_t;

  typedef enum logic [2:0] {
    after_power_up,
    after_good_card,
    after_bad_card,
    after_card_timeout,
    after_answer_timeout,
    after_failed_check
  } crs_ante_t;

  typedef enum logic [2:0] {
    op_activate,
    op_challenge_reply,
    op_get_state,
    op_close,
    op_open,
    op_secure
  } crs_op_t;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic    valid;
    crs_op_t op;
    logic    check_ok;
    logic    alt_code;
    logic    arg;
  } crs_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    crs_main_t  state;
    crs_ante_t  ante;
  } crs_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       second;
    logic       done;
    logic       good;
  } crs_card_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       second;
    logic       last;
    logic       empty;
  } crs_rpt_t;

endpackage
`default_nettype wire

// ---- include/crs_regs.svh ----
// Overview of operation
// - Power-up enters wait_for_activation, after_power_up.
// - Valid activate moves to challenge wait, 00.
// - Valid challenge reply moves to wait_for_card, 00.
// - Activation steps keep the previous antecedent.
// - Good card sends data, after_good_card.
// - Card timeout sends empty report, after_card_timeout.
// - Invalid reply gives after_failed_check, 02 or 04.
// - Reply timeout silently gives after_answer_timeout.
// - Late challenge reply answers 07.
// - Late reply leaves state and antecedent unchanged.
// - State query works in any state except low power.
// - State is main state plus antecedent.
// - Card data may come as two blocks.
// - Next card accepted without added delay.
// - Optionally withhold card data until mutual authentication.
// - Commands only after attach identification completes.
// - Session close enters low power until reopened.
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH

// ----------------------------------------------------------------------
// Response codes
// ----------------------------------------------------------------------
`define CRS_RSP_OK       8'h00
`define CRS_RSP_FAIL     8'h02
`define CRS_RSP_FAIL_ALT 8'h04
`define CRS_RSP_SEQ_ERR  8'h07

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CRS_TIMER_W      32

`endif

// ---- rtl/crs_session.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"

module crs_session
  import crs_pkg::*;
#(
  parameter int TW = `CRS_TIMER_W
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          clk_en_i,
  input  wire logic          attach_pin_i,
  input  wire logic          ident_ok_i,
  input  wire logic          mutual_ok_i,
  input  wire logic [TW-1:0] reply_limit_i,
  input  wire logic [TW-1:0] card_limit_i,
  input  wire crs_cmd_t      cmd_i,
  input  wire crs_card_t     card_i,
  output crs_rsp_t           rsp_o,
  output crs_rpt_t           rpt_o,
  output crs_main_t          state_o,
  output crs_ante_t          ante_o,
  output logic               low_power_o,
  output logic               secure_o,
  output logic               avail_o
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  crs_main_t       main_st;
  crs_ante_t       ante;
  logic            low_power;
  logic            secure;
  logic            avail;
  logic            att_s1;
  logic            att_s2;
  logic [TW-1:0]   timer;
  crs_rsp_t        rsp;
  crs_rpt_t        rpt;

  crs_main_t       next_main;
  crs_ante_t       next_ante;
  logic            next_low_power;
  logic            next_secure;
  crs_rsp_t        next_rsp;
  crs_rpt_t        next_rpt;

  // --------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------
  wire logic          in_act   = (main_st == wait_for_activation);
  wire logic          in_chal  = (main_st == wait_for_challenge_answer);
  wire logic          in_card  = (main_st == wait_for_card);
  wire logic [TW-1:0] limit    = in_chal ? reply_limit_i : card_limit_i;
  wire logic          timing   = (in_chal || in_card) && !low_power;
  wire logic          time_up  = timing && (timer >= limit);
  wire logic          card_end = in_card && !low_power && card_i.done;
  wire logic          ev_any   = card_end || time_up;
  wire logic          cmd_live = cmd_i.valid && avail;
  wire logic          cmd_take = cmd_live && !low_power && !ev_any;
  wire logic          allow    = !secure || mutual_ok_i;
  wire logic          fwd      = in_card && !low_power && card_i.valid && allow;
  wire logic          is_act   = (cmd_i.op == op_activate);
  wire logic          is_reply = (cmd_i.op == op_challenge_reply);
  wire logic          entering = (next_main != main_st);

  // Keeps every response stamped with the state it answered from.
  function automatic crs_rsp_t mk_rsp(input logic [7:0] code,
                                      input crs_main_t st,
                                      input crs_ante_t an);
    crs_rsp_t r;
    r.valid = 1'b1;
    r.code  = code;
    r.state = st;
    r.ante  = an;
    return r;
  endfunction

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  // A command landing in the same cycle as a card or timer event refers
  // to a state that is already gone, so it gets a sequence error.
  always_comb begin
    next_main      = main_st;
    next_ante      = ante;
    next_low_power = low_power;
    next_secure    = secure;
    next_rsp       = '0;
    next_rpt       = '0;
    if (fwd) begin
      next_rpt.valid  = 1'b1;
      next_rpt.data   = card_i.data;
      next_rpt.second = card_i.second;
      next_rpt.last   = card_i.done;
    end
    if (card_end) begin
      next_main = wait_for_activation;
      next_ante = card_i.good ? after_good_card : after_bad_card;
    end else if (time_up && in_card) begin
      next_main       = wait_for_activation;
      next_ante       = after_card_timeout;
      next_rpt        = '0;
      next_rpt.valid  = 1'b1;
      next_rpt.empty  = 1'b1;
      next_rpt.last   = 1'b1;
    end else if (time_up) begin
      next_main = wait_for_activation;
      next_ante = after_answer_timeout;
    end
    if (cmd_live && ev_any) begin
      next_rsp = mk_rsp(`CRS_RSP_SEQ_ERR, main_st, ante);
    end else if (cmd_live && low_power) begin
      if (cmd_i.op == op_open) begin
        next_low_power = 1'b0;
        next_rsp       = mk_rsp(`CRS_RSP_OK, main_st, ante);
      end
    end else if (cmd_take) begin
      unique case (cmd_i.op)
        op_get_state: begin
          next_rsp = mk_rsp(`CRS_RSP_OK, main_st, ante);
        end
        op_close: begin
          next_low_power = 1'b1;
          next_rsp       = mk_rsp(`CRS_RSP_OK, main_st, ante);
        end
        op_open: begin
          next_rsp = mk_rsp(`CRS_RSP_OK, main_st, ante);
        end
        op_secure: begin
          next_secure = cmd_i.arg;
          next_rsp    = mk_rsp(`CRS_RSP_OK, main_st, ante);
        end
        op_activate: begin
          if (in_act) begin
            next_main = wait_for_challenge_answer;
            next_rsp  = mk_rsp(`CRS_RSP_OK, main_st, ante);
          end else begin
            next_rsp = mk_rsp(`CRS_RSP_SEQ_ERR, main_st, ante);
          end
        end
        op_challenge_reply: begin
          if (in_chal && cmd_i.check_ok) begin
            next_main = wait_for_card;
            next_rsp  = mk_rsp(`CRS_RSP_OK, main_st, ante);
          end else if (in_chal) begin
            next_main = wait_for_activation;
            next_ante = after_failed_check;
            next_rsp  = mk_rsp(cmd_i.alt_code ? `CRS_RSP_FAIL_ALT : `CRS_RSP_FAIL,
                               main_st, ante);
          end else begin
            next_rsp = mk_rsp(`CRS_RSP_SEQ_ERR, main_st, ante);
          end
        end
        default: begin
          next_rsp = mk_rsp(`CRS_RSP_SEQ_ERR, main_st, ante);
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Attach pin synchroniser and availability
  // --------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      att_s1 <= 1'b0;
      att_s2 <= 1'b0;
    end else if (clk_en_i) begin
      att_s1 <= attach_pin_i;
      att_s2 <= att_s1;
    end
  end

  // Detaching drops availability, so the next attach must identify again.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      avail <= 1'b0;
    end else if (clk_en_i) begin
      avail <= att_s2 && (avail || ident_ok_i);
    end
  end

  // --------------------------------------------------------------------
  // Main registers
  // --------------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      main_st   <= wait_for_activation;
      ante      <= after_power_up;
      low_power <= 1'b0;
      secure    <= 1'b0;
    end else if (clk_en_i) begin
      main_st   <= next_main;
      ante      <= next_ante;
      low_power <= next_low_power;
      secure    <= next_secure;
    end
  end

  // The wait timer is held at zero in low power instead of expiring unseen.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      timer <= '0;
    end else if (clk_en_i) begin
      if (entering || !timing) begin
        timer <= '0;
      end else begin
        timer <= timer + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rsp <= '0;
      rpt <= '0;
    end else if (clk_en_i) begin
      rsp <= next_rsp;
      rpt <= next_rpt;
    end
  end

  assign rsp_o       = rsp;
  assign rpt_o       = rpt;
  assign state_o     = main_st;
  assign ante_o      = ante;
  assign low_power_o = low_power;
  assign secure_o    = secure;
  assign avail_o     = avail;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  wire logic step = clk_en_i;

  a_activate_move: assert property (
    step && cmd_take && is_act && in_act
    |=> main_st == wait_for_challenge_answer && rsp_o.valid
        && rsp_o.code == 8'h00)
    else $error("activate did not move to challenge wait");

  a_reply_move: assert property (
    step && cmd_take && is_reply && in_chal && cmd_i.check_ok
    |=> main_st == wait_for_card && rsp_o.code == 8'h00)
    else $error("good reply did not move to card wait");

  a_ante_kept: assert property (
    step && cmd_take && (is_act || (is_reply && cmd_i.check_ok))
    |=> ante == $past(ante))
    else $error("activation step changed antecedent");

  a_good_card: assert property (
    step && card_end && card_i.good
    |=> main_st == wait_for_activation && ante == after_good_card)
    else $error("good card not closed correctly");

  a_bad_card: assert property (
    step && card_end && !card_i.good
    |=> main_st == wait_for_activation && ante == after_bad_card)
    else $error("bad card not closed correctly");

  a_card_timeout: assert property (
    step && time_up && in_card && !card_end
    |=> rpt_o.valid && rpt_o.empty && ante == after_card_timeout)
    else $error("card timeout report missing");

  a_failed_check: assert property (
    step && cmd_take && is_reply && in_chal && !cmd_i.check_ok
    |=> ante == after_failed_check
        && (rsp_o.code == 8'h02 || rsp_o.code == 8'h04))
    else $error("failed check not reported");

  a_answer_silent: assert property (
    step && time_up && in_chal && !cmd_live
    |=> ante == after_answer_timeout && !rsp_o.valid && !rpt_o.valid)
    else $error("reply timeout was not silent");

  a_late_reply: assert property (
    step && cmd_take && is_reply && in_act && ante == after_answer_timeout
    |=> rsp_o.code == 8'h07 && main_st == wait_for_activation
        && ante == after_answer_timeout)
    else $error("late reply not refused");

  a_query_any: assert property (
    step && cmd_take && cmd_i.op == op_get_state
    |=> rsp_o.valid && rsp_o.state == $past(main_st)
        && rsp_o.ante == $past(ante))
    else $error("state query answer wrong");

  // A byte without done that meets the card timeout is dropped, because the empty report wins.
  a_byte_forward: assert property (
    step && in_card && !low_power && card_i.valid && (!secure || mutual_ok_i)
        && timer < card_limit_i
    |=> rpt_o.valid && rpt_o.data == $past(card_i.data)
        && rpt_o.second == $past(card_i.second))
    else $error("card byte not forwarded");

  a_data_withheld: assert property (
    step && card_i.valid && secure && !mutual_ok_i && !time_up
    |=> !rpt_o.valid)
    else $error("card data leaked before authentication");

  a_not_avail: assert property (
    step && cmd_i.valid && !avail |=> !rsp_o.valid)
    else $error("command answered before identification");

  a_close_low: assert property (
    step && cmd_take && cmd_i.op == op_close
    |=> low_power_o
        ##1 (low_power_o || ($past(cmd_i.valid) && $past(cmd_i.op) == op_open)))
    else $error("session close did not enter low power");

  a_quiet_low: assert property (
    step && low_power && cmd_i.valid && cmd_i.op != op_open
    |=> !rsp_o.valid)
    else $error("command answered in low power");

  a_timer_entry: assert property (
    step && entering && next_main != wait_for_activation
    |=> timer == '0)
    else $error("timer did not restart on entry");

  a_timer_bound: assert property (
    step && in_chal && !low_power && !cmd_live && timer < reply_limit_i
    |=> main_st == wait_for_challenge_answer)
    else $error("reply wait ended before its limit");

  a_frozen_hold: assert property (
    !step
    |=> $stable(main_st) && $stable(ante) && $stable(timer) && $stable(rsp_o))
    else $error("state moved while clock enable was low");

  c_good_read: cover property (
    step && cmd_take && is_reply && cmd_i.check_ok ##[1:50] card_end);
  c_card_timeout: cover property (rpt_o.valid && rpt_o.empty);
  c_late_reply: cover property (rsp_o.valid && rsp_o.code == 8'h07);
  c_two_blocks: cover property (rpt_o.valid && rpt_o.second);
  c_frozen: cover property (!step && in_card);

endmodule // crs_session
`default_nettype wire

// ---- tb/crs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module crs_host_model
  import crs_pkg::*;
(
  input  wire logic     clock_i,
  output var crs_cmd_t  cmd_o,
  output var crs_card_t card_o
);
  // ----------------------------------------------------------------------
  // Host side of the command and card streams
  // ----------------------------------------------------------------------
  // Idle check_ok and data lines flip so that a stale value never passes for a fresh one.
  initial begin
    cmd_o  = '0;
    card_o = '0;
  end

  task automatic send(input crs_op_t op, input logic ok, input logic alt, input logic arg);
    @(posedge clock_i);
    #1;
    cmd_o = '{valid: 1'b1, op: op, check_ok: ok, alt_code: alt, arg: arg};
    @(posedge clock_i);
    #1;
    cmd_o.valid    = 1'b0;
    cmd_o.check_ok = ~cmd_o.check_ok;
  endtask

  task automatic swipe(input logic [7:0] d, input logic sec, input logic dn, input logic gd);
    @(posedge clock_i);
    #1;
    card_o = '{valid: 1'b1, data: d, second: sec, done: dn, good: gd};
    @(posedge clock_i);
    #1;
    card_o.valid = 1'b0;
    card_o.done  = 1'b0;
    card_o.data  = ~d;
  endtask
endmodule // crs_host_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crs_pkg::*;
  logic        clock_i      = 1'b0;
  logic        rst_i        = 1'b1;
  logic        clk_en       = 1'b1;
  logic        attach_pin_i = 1'b1;
  logic        ident_ok_i   = 1'b0;
  logic        mutual_ok_i  = 1'b0;
  logic [31:0] lim          = 32'h5;
  crs_cmd_t    cmd;
  crs_card_t   card;
  crs_rsp_t    rsp_o;
  crs_rpt_t    rpt_o;
  crs_main_t   state_o;
  crs_ante_t   ante_o;
  logic        low_power_o;
  logic        secure_o;
  logic        avail_o;
  int          mismatches   = 0;
  int          comparisons  = 0;
  crs_rsp_t    q_rsp[$];
  crs_rpt_t    q_rpt[$];
  logic [7:0]  b0;
  logic [7:0]  b1;

  always #10 clock_i = ~clock_i;

  crs_session u_crs_session (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en),
    .attach_pin_i(attach_pin_i), .ident_ok_i(ident_ok_i), .mutual_ok_i(mutual_ok_i),
    .reply_limit_i(lim), .card_limit_i(lim), .cmd_i(cmd), .card_i(card), .rsp_o(rsp_o),
    .rpt_o(rpt_o), .state_o(state_o), .ante_o(ante_o), .low_power_o(low_power_o),
    .secure_o(secure_o), .avail_o(avail_o));
  crs_host_model u_crs_host_model (.clock_i(clock_i), .cmd_o(cmd), .card_o(card));

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (e !== g) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic er(input logic [7:0] c, input crs_main_t s, input crs_ante_t a);
    q_rsp.push_back('{valid: 1'b1, code: c, state: s, ante: a});
  endtask
  task automatic ec(input logic [7:0] d, input logic sec, input logic l, input logic em);
    q_rpt.push_back('{valid: 1'b1, data: d, second: sec, last: l, empty: em});
  endtask
  task automatic st(input crs_main_t s, input crs_ante_t a);
    chk("state", {11'h0, s, a}, {11'h0, state_o, ante_o});
  endtask
  task automatic cmp_rsp(input crs_rsp_t g);
    chk("rsp", q_rsp.size() ? q_rsp.pop_front() : '0, g);
  endtask
  task automatic cmp_rpt(input crs_rpt_t g);
    chk("rpt", q_rpt.size() ? q_rpt.pop_front() : '0, g);
  endtask
  // Sampling on the falling edge keeps the monitor clear of the launch edge.
  always @(negedge clock_i) begin
    if (rsp_o.valid !== 1'b0) cmp_rsp(rsp_o);
    if (rpt_o.valid !== 1'b0) cmp_rpt(rpt_o);
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400us;
    mismatches++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic arm(input crs_ante_t a);
    er(8'h00, wait_for_activation, a);
    u_crs_host_model.send(op_activate, 1'b0, 1'b0, 1'b0);
    st(wait_for_challenge_answer, a);
    er(8'h00, wait_for_challenge_answer, a);
    u_crs_host_model.send(op_challenge_reply, 1'b1, 1'b0, 1'b0);
    st(wait_for_card, a);
  endtask
  initial begin
    void'($urandom(73057));
    repeat (8) @(posedge clock_i);
    #1 rst_i = 1'b0;
    st(wait_for_activation, after_power_up);
    u_crs_host_model.send(op_get_state, 1'b0, 1'b0, 1'b0);
    ident_ok_i = 1'b1;
    for (int i = 0; i < 20 && avail_o !== 1'b1; i++) @(posedge clock_i);
    chk("avail", 16'h1, {15'h0, avail_o});
    er(8'h00, wait_for_activation, after_power_up);
    u_crs_host_model.send(op_get_state, 1'b0, 1'b0, 1'b0);
    arm(after_power_up);
    b0 = 8'($urandom());
    b1 = 8'($urandom());
    ec(b0, 1'b0, 1'b0, 1'b0);
    u_crs_host_model.swipe(b0, 1'b0, 1'b0, 1'b0);
    ec(b1, 1'b1, 1'b1, 1'b0);
    u_crs_host_model.swipe(b1, 1'b1, 1'b1, 1'b1);
    @(negedge clock_i);
    st(wait_for_activation, after_good_card);
    arm(after_good_card);
    @(posedge clock_i);
    #1 clk_en = 1'b0;
    repeat (20) @(posedge clock_i);
    #1 clk_en = 1'b1;
    st(wait_for_card, after_good_card);
    ec(8'h00, 1'b0, 1'b1, 1'b1);
    repeat (32'd4 + lim) @(posedge clock_i);
    st(wait_for_activation, after_card_timeout);
    for (int k = 0; k < 2; k++) begin
      er(8'h00, wait_for_activation, k ? after_failed_check : after_card_timeout);
      u_crs_host_model.send(op_activate, 1'b0, 1'b0, 1'b0);
      er(k ? 8'h04 : 8'h02, wait_for_challenge_answer,
         k ? after_failed_check : after_card_timeout);
      u_crs_host_model.send(op_challenge_reply, 1'b0, k[0], 1'b0);
      st(wait_for_activation, after_failed_check);
    end
    er(8'h00, wait_for_activation, after_failed_check);
    u_crs_host_model.send(op_activate, 1'b0, 1'b0, 1'b0);
    repeat (32'd4 + lim) @(posedge clock_i);
    st(wait_for_activation, after_answer_timeout);
    er(8'h07, wait_for_activation, after_answer_timeout);
    u_crs_host_model.send(op_challenge_reply, 1'b1, 1'b0, 1'b0);
    st(wait_for_activation, after_answer_timeout);
    er(8'h00, wait_for_activation, after_answer_timeout);
    u_crs_host_model.send(op_secure, 1'b0, 1'b0, 1'b1);
    chk("secure", 16'h1, {15'h0, secure_o});
    arm(after_answer_timeout);
    u_crs_host_model.swipe(b0, 1'b0, 1'b1, 1'b0);
    @(negedge clock_i);
    st(wait_for_activation, after_bad_card);
    er(8'h00, wait_for_activation, after_bad_card);
    u_crs_host_model.send(op_close, 1'b0, 1'b0, 1'b0);
    chk("low_power", 16'h1, {15'h0, low_power_o});
    u_crs_host_model.send(op_get_state, 1'b0, 1'b0, 1'b0);
    er(8'h00, wait_for_activation, after_bad_card);
    u_crs_host_model.send(op_open, 1'b0, 1'b0, 1'b0);
    chk("low_power", 16'h0, {15'h0, low_power_o});
    mutual_ok_i = 1'b1;
    arm(after_bad_card);
    ec(b1, 1'b0, 1'b1, 1'b0);
    u_crs_host_model.swipe(b1, 1'b0, 1'b1, 1'b1);
    @(negedge clock_i);
    st(wait_for_activation, after_good_card);
    repeat (3) @(posedge clock_i);
    chk("pending", 16'h0, 16'(q_rsp.size() + q_rpt.size()));
    print_verdict();
  end
endmodule // tb
`default_nettype wire
